// ---- hdl/lsr_dark_track.sv ----
// dark level hysteresis tracker for one sensor
`timescale 1ns/1ps
`include "lsr_defs.svh"
module lsr_dark_track
    import lsr_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic nrst_i,
    lsr_level_if.tracker lvl
);
    logic dark_q;
    logic chg_q;
    lsr_code_t trip_c;
    lsr_code_t rise_c;
    // settings step 0.5 uA, codes step 0.125 uA: scale by four
    assign trip_c = lsr_code_t'({lvl.trip, 2'b00});
    assign rise_c = lsr_code_t'({lvl.trip, 2'b00}) + lsr_code_t'({lvl.hyst, 2'b00});
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dark_q <= 1'b0;
            chg_q <= 1'b0;
        end else begin
            chg_q <= 1'b0;
            if (lvl.code_valid) begin
                if (!dark_q && lvl.code < trip_c) begin
                    dark_q <= 1'b1;
                    chg_q <= 1'b1;
                end else if (dark_q && lvl.code > rise_c) begin
                    dark_q <= 1'b0;
                    chg_q <= 1'b1;
                end
            end
        end
    end
    assign lvl.dark = dark_q;
    assign lvl.changed = chg_q;
endmodule : lsr_dark_track

// ---- hdl/lsr_defs.svh ----
// constants for the light sensor readout block
`ifndef LSR_DEFS_SVH
`define LSR_DEFS_SVH
`define LSR_OFS_DARK_HYST2 8'h3a
`define LSR_OFS_RES1_HI 8'h3b
`define LSR_OFS_RES1_LO 8'h3c
`define LSR_OFS_RES2_HI 8'h3d
`define LSR_OFS_RES2_LO 8'h3e
`define LSR_RST_DARK_HYST 8'h00
`define LSR_RST_RESULT 13'h0000
`define LSR_HI_MSB 4
`define LSR_RES_W 13
`define LSR_FULL_SCALE_CODES 13'h1f40
`define LSR_HYST_SHIFT 2
`endif

// ---- hdl/lsr_level_if.sv ----
// interface between the top and the per-sensor dark level tracker
`timescale 1ns/1ps
interface lsr_level_if;
    logic [12:0] code;
    logic code_valid;
    logic [7:0] trip;
    logic [7:0] hyst;
    logic dark;
    logic changed;
    modport tracker (input code, input code_valid, input trip, input hyst,
                     output dark, output changed);
    modport top (output code, output code_valid, output trip, output hyst,
                 input dark, input changed);
endinterface : lsr_level_if

// ---- hdl/lsr_pkg.sv ----
// types for the light sensor readout block
package lsr_pkg;
    typedef enum logic [1:0] {LSR_IDLE, LSR_CONVERT, LSR_UPDATE} lsr_state_t;
    typedef logic [12:0] lsr_code_t;
endpackage : lsr_pkg

// ---- hdl/lsr_readout.sv ----
// light sensor readout: result registers, dark hysteresis and level machine
//
// Overview of operation
// - leave dark when above trip plus hysteresis
// - dark hysteresis is a full 8-bit field
// - upper sensor 1 register holds bits 12:8
// - lower register holds bits 7:0, latest conversion
// - sensor 2 result uses same register pair layout
// - code scales 0.125 uA per step, 8000 full
// - interrupt host whenever lighting level changes
// - below dark trip enters dark, sets flag
// - clear force bit after results updated
`timescale 1ns/1ps
`include "lsr_defs.svh"
module lsr_readout
    import lsr_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [7:0] dark_trip_point_s1_i,
    input wire logic [7:0] dark_hyst_field_s1_i,
    input wire logic [7:0] dark_trip_point_s2_i,
    input wire logic force_req_i,
    output logic force_busy_o,
    output logic conv_start_o,
    input wire logic conv_done_i,
    input wire logic [12:0] conv_code1_i,
    input wire logic [12:0] conv_code2_i,
    output logic dark_level_flag1_o,
    output logic dark_level_flag2_o,
    output logic level_change_o
);
    lsr_state_t state_q;
    logic [7:0] hyst2_q;
    lsr_code_t res1_q;
    lsr_code_t res2_q;
    logic force_q;
    logic [7:0] rdata_q;
    logic chg_q;
    lsr_code_t cin1;
    lsr_code_t cin2;
    lsr_level_if lvl1 ();
    lsr_level_if lvl2 ();

    // clip to full scale so a stray converter code never exceeds 8000 steps
    function automatic lsr_code_t lsr_clip(input lsr_code_t c);
        lsr_clip = (c > `LSR_FULL_SCALE_CODES) ? `LSR_FULL_SCALE_CODES : c;
    endfunction : lsr_clip

    function automatic logic [7:0] lsr_hi(input lsr_code_t c);
        lsr_hi = {3'h0, c[12:8]};
    endfunction : lsr_hi

    assign cin1 = lsr_clip(conv_code1_i);
    assign cin2 = lsr_clip(conv_code2_i);

    // software writes only the hysteresis; result offsets drop writes
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hyst2_q <= `LSR_RST_DARK_HYST;
        end else if (reg_wr_i && reg_addr_i == `LSR_OFS_DARK_HYST2) begin
            hyst2_q <= reg_wdata_i;
        end
    end

    // conversion sequencer; force request is held until results land
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= LSR_IDLE;
            force_q <= 1'b0;
        end else begin
            unique case (state_q)
                LSR_IDLE: begin
                    if (force_req_i) begin
                        force_q <= 1'b1;
                        state_q <= LSR_CONVERT;
                    end
                end
                LSR_CONVERT: begin
                    if (conv_done_i) begin
                        state_q <= LSR_UPDATE;
                    end
                end
                LSR_UPDATE: begin
                    force_q <= 1'b0;
                    state_q <= LSR_IDLE;
                end
            endcase
        end
    end

    // results refresh on every finished conversion, forced or free-running
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            res1_q <= `LSR_RST_RESULT;
            res2_q <= `LSR_RST_RESULT;
        end else if (conv_done_i) begin
            res1_q <= cin1;
            res2_q <= cin2;
        end
    end

    assign lvl1.code = res1_q;
    assign lvl1.code_valid = (state_q == LSR_UPDATE) || (state_q == LSR_IDLE && !force_q);
    assign lvl1.trip = dark_trip_point_s1_i;
    assign lvl1.hyst = dark_hyst_field_s1_i;
    assign lvl2.code = res2_q;
    assign lvl2.code_valid = lvl1.code_valid;
    assign lvl2.trip = dark_trip_point_s2_i;
    assign lvl2.hyst = hyst2_q;

    lsr_dark_track u_trk1 (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .lvl(lvl1.tracker)
    );
    lsr_dark_track u_trk2 (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .lvl(lvl2.tracker)
    );

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            chg_q <= 1'b0;
        end else begin
            chg_q <= lvl1.changed | lvl2.changed;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_q <= 8'h00;
        end else begin
            unique case (reg_addr_i)
                `LSR_OFS_DARK_HYST2: rdata_q <= hyst2_q;
                `LSR_OFS_RES1_HI: rdata_q <= lsr_hi(res1_q);
                `LSR_OFS_RES1_LO: rdata_q <= res1_q[7:0];
                `LSR_OFS_RES2_HI: rdata_q <= lsr_hi(res2_q);
                `LSR_OFS_RES2_LO: rdata_q <= res2_q[7:0];
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign reg_rdata_o = rdata_q;
    assign force_busy_o = force_q;
    assign conv_start_o = (state_q == LSR_CONVERT);
    assign dark_level_flag1_o = lvl1.dark;
    assign dark_level_flag2_o = lvl2.dark;
    assign level_change_o = chg_q;
endmodule : lsr_readout

// ---- verif/lsr_conv_model.sv ----
// converter model answering a start with a done pulse and two codes
`timescale 1ns/1ps
module lsr_conv_model #(parameter int DLY = 3) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic start_i,
    input wire logic [12:0] c1_i,
    input wire logic [12:0] c2_i,
    output logic done_o,
    output logic [12:0] code1_o,
    output logic [12:0] code2_o
);
    int cnt;
    // codes only hold with done; the inverse exposes a stale capture
    assign code1_o = done_o ? c1_i : ~c1_i;
    assign code2_o = done_o ? c2_i : ~c2_i;
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt <= 0;
            done_o <= 1'b0;
        end else begin
            cnt <= (start_i && !done_o) ? cnt + 1 : 0;
            done_o <= start_i && !done_o && cnt == DLY;
        end
    end
endmodule : lsr_conv_model

// ---- verif/lsr_readout_asserts.sv ----
// port assertions for the light sensor readout
`timescale 1ns/1ps
module lsr_readout_asserts (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [7:0] dark_trip_point_s1_i,
    input wire logic [7:0] dark_hyst_field_s1_i,
    input wire logic force_req_i,
    input wire logic force_busy_o,
    input wire logic conv_start_o,
    input wire logic conv_done_i,
    input wire logic [12:0] conv_code1_i,
    input wire logic dark_level_flag1_o,
    input wire logic dark_level_flag2_o,
    input wire logic level_change_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    a_hi_zero: assert property ($past(reg_addr_i) inside {8'h3b, 8'h3d} |-> reg_rdata_o[7:5] == 3'h0)
        else $error("spare bits set");
    a_busy_set: assert property (force_req_i && !force_busy_o |=> force_busy_o && conv_start_o)
        else $error("force not taken");
    a_start_busy: assert property (conv_start_o |-> force_busy_o)
        else $error("busy low in convert");
    a_done_ends: assert property (conv_start_o && conv_done_i |=> !conv_start_o ##1 !force_busy_o)
        else $error("force bit timing");
    a_chg_pulse: assert property (level_change_o |=> !level_change_o)
        else $error("change pulse long");
    a_chg_cause: assert property ($changed(dark_level_flag1_o) || $changed(dark_level_flag2_o) |=> level_change_o)
        else $error("no change pulse");
    a_dark_enter: assert property (conv_start_o && conv_done_i && conv_code1_i < {dark_trip_point_s1_i, 2'b00} |-> ##2 dark_level_flag1_o)
        else $error("dark not entered");
    a_dark_exit: assert property (conv_start_o && conv_done_i && conv_code1_i > {dark_trip_point_s1_i, 2'b00} + {dark_hyst_field_s1_i, 2'b00} |-> ##2 !dark_level_flag1_o)
        else $error("dark not left");
endmodule : lsr_readout_asserts
bind lsr_readout lsr_readout_asserts lsr_readout_asserts_i (.*);

// ---- verif/lsr_readout_test.sv ----
// self-checking bench for the light sensor readout
`timescale 1ns/1ps
module lsr_readout_test;
    logic core_clk_i = 0, nrst_i = 0, reg_wr_i = 0, force_req_i = 0;
    logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, dark_trip_point_s1_i = 8'h0a;
    logic [7:0] dark_hyst_field_s1_i = 8'h05, dark_trip_point_s2_i = 8'h0a, reg_rdata_o;
    logic [12:0] c1 = 0, c2 = 0, conv_code1_i, conv_code2_i;
    logic force_busy_o, conv_start_o, conv_done_i;
    logic dark_level_flag1_o, dark_level_flag2_o, level_change_o;
    int miscompares = 0, n_tests = 0, cyc = 0;
    lsr_readout lsr_readout_i (.*);
    lsr_conv_model lsr_conv_model_i (.core_clk_i, .nrst_i, .start_i(conv_start_o), .c1_i(c1),
        .c2_i(c2), .done_o(conv_done_i), .code1_o(conv_code1_i), .code2_o(conv_code2_i));
    always #25 core_clk_i = ~core_clk_i;
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr_i = a;
        @(negedge core_clk_i);
        chk(reg_rdata_o, e);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1;
        @(negedge core_clk_i);
        reg_wr_i = 0;
    endtask : wr
    task automatic conv(input logic [12:0] x, input logic [12:0] y);
        c1 = x;
        c2 = y;
        force_req_i = 1;
        @(negedge core_clk_i);
        force_req_i = 0;
        repeat (20) if (force_busy_o) @(negedge core_clk_i);
        @(negedge core_clk_i);
    endtask : conv
    task automatic t_regs();
        rd(8'h3a, 8'h00);
        wr(8'h3a, 8'hff);
        rd(8'h3a, 8'hff);
        wr(8'h3c, 8'h55);
        rd(8'h3c, 8'h00);
        rd(8'h40, 8'h00);
    endtask : t_regs
    task automatic t_results();
        conv(13'h1abc, 13'h0123);
        rd(8'h3b, 8'h1a);
        rd(8'h3c, 8'hbc);
        rd(8'h3d, 8'h01);
        rd(8'h3e, 8'h23);
        conv(13'h1fff, 13'h0000);
        rd(8'h3b, 8'h1f);
        rd(8'h3c, 8'h40);
    endtask : t_results
    task automatic t_dark();
        wr(8'h3a, 8'h05);
        // sensor 2 is left dark by the zero code above; bring it back first
        conv(13'd100, 13'd100);
        chk({7'h0, dark_level_flag2_o}, 8'h00);
        chk({7'h0, level_change_o}, 8'h01);
        conv(13'd39, 13'd39);
        chk({7'h0, dark_level_flag2_o}, 8'h01);
        chk({7'h0, dark_level_flag1_o}, 8'h01);
        chk({7'h0, level_change_o}, 8'h01);
        conv(13'd60, 13'd60);
        chk({7'h0, dark_level_flag2_o}, 8'h01);
        chk({7'h0, level_change_o}, 8'h00);
        conv(13'd61, 13'd61);
        chk({7'h0, dark_level_flag2_o}, 8'h00);
        chk({7'h0, level_change_o}, 8'h01);
    endtask : t_dark
    task automatic test_done();
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            miscompares++;
            test_done();
        end
    end
    initial begin
        repeat (2) @(negedge core_clk_i);
        nrst_i = 1;
        t_regs();
        t_results();
        t_dark();
        test_done();
    end
endmodule : lsr_readout_test
